// ### design/tse_pkg.sv
// Purpose: shared constants for the split/event timer and its host end
// Assumes: byte-wide register port, 6-bit byte address
// Notes: one offset serves both modes; only the meaning of a byte changes
package tse_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   // timer register offsets (byte addresses)
   localparam logic [5:0] ADDR_CONTROL_A = 6'h00;
   localparam logic [5:0] ADDR_CONTROL_D = 6'h03;
   localparam logic [5:0] ADDR_CONTROL_E_CLR = 6'h04;
   localparam logic [5:0] ADDR_CONTROL_E_SET = 6'h05;
   localparam logic [5:0] ADDR_EVENT_CONTROL = 6'h09;
   localparam logic [5:0] ADDR_INT_ENABLE = 6'h0A;
   localparam logic [5:0] ADDR_INT_FLAG = 6'h0B;
   localparam logic [5:0] ADDR_COUNT_LO = 6'h20;
   localparam logic [5:0] ADDR_COUNT_HI = 6'h21;
   localparam logic [5:0] ADDR_PERIOD_LO = 6'h26;
   localparam logic [5:0] ADDR_PERIOD_HI = 6'h27;
   localparam logic [5:0] ADDR_COMPARE_BASE = 6'h28;
   // field positions
   localparam int POS_ENABLE = 0;
   localparam int POS_PRESC = 1;
   localparam int POS_SPLIT = 0;
   localparam int POS_DIR = 0;
   localparam int POS_CMD = 2;
   localparam int POS_EVT_EN = 0;
   localparam int POS_EVT_ACT = 1;
   localparam int FLAG_OVER_LOW = 0;
   localparam int FLAG_HIGH_UNDER = 1;
   localparam int FLAG_COMPARE = 4;
   localparam logic [7:0] FLAG_MASK = 8'h73;
   // reset values
   localparam logic [15:0] RST_PERIOD = 16'hFFFF;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [3:0] RST_CTRL = 4'h0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int PRESC_W = 10;
   typedef enum logic [1:0] {
      TSE_CMD_NONE = 2'b00,
      TSE_CMD_UPDATE = 2'b01,
      TSE_CMD_RESTART = 2'b10,
      TSE_CMD_RESET = 2'b11
   } tse_cmd_t;
   typedef enum logic [2:0] {
      TSE_ACT_RISE = 3'b000,
      TSE_ACT_ANY_EDGE = 3'b001,
      TSE_ACT_HIGH = 3'b010,
      TSE_ACT_UPDOWN = 3'b011
   } tse_act_t;
   // host register offsets (word index on the host software port)
   localparam logic [1:0] HOST_ACCESS = 2'h0;
   localparam logic [1:0] HOST_READBACK = 2'h1;
   localparam logic [1:0] HOST_EVENT = 2'h2;
   localparam logic [1:0] HOST_STATUS = 2'h3;
endpackage

// ### design/tse_if.sv
// Purpose: link between the timer and its host (register port, events, requests)
// Assumes: one clock on both ends
// Notes: all signals are plain logic, no tri-state
`timescale 1ns/100ps
`default_nettype none
interface tse_if;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_we;
   logic reg_re;
   logic [7:0] reg_rdata;
   logic event_in;
   logic overflow_or_low_underflow_event;
   logic high_byte_underflow;
   logic [2:0] compare_event;
   logic [7:0] irq_request;
   modport dev (input reg_addr, reg_wdata, reg_we, reg_re, event_in,
      output reg_rdata, overflow_or_low_underflow_event, high_byte_underflow, compare_event, irq_request);
   modport host (output reg_addr, reg_wdata, reg_we, reg_re, event_in,
      input reg_rdata, overflow_or_low_underflow_event, high_byte_underflow, compare_event, irq_request);
endinterface
`default_nettype wire

// ### design/tse_timer.sv
// Purpose: 16-bit timer with split mode, event pulses, event input and interrupt flags
// Assumes: register port from the host on the same clock; read data one cycle after the strobe
// Notes: no waveform output, no buffered registers; 16-bit values are byte accessed
`timescale 1ns/100ps
`default_nettype none
module tse_timer import tse_pkg::*; (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // link to the host
   tse_if.dev link,
   // status
   output logic o_running,
   output logic o_split_active
);
   // prescaler mask: all ones below the divide ratio
   function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
      case (sel)
         3'h0: div_mask = 10'h000;
         3'h1: div_mask = 10'h001;
         3'h2: div_mask = 10'h003;
         3'h3: div_mask = 10'h007;
         3'h4: div_mask = 10'h00F;
         3'h5: div_mask = 10'h03F;
         3'h6: div_mask = 10'h0FF;
         default: div_mask = 10'h3FF;
      endcase
   endfunction

   // byte lane write into a 16-bit value
   function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi, input logic [7:0] b);
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction

   logic [3:0] ctrl_a_ff;
   logic split_ff;
   logic [3:0] evt_ctrl_ff;
   logic [7:0] int_en_ff;
   logic [7:0] flag_ff;
   logic [7:0] nxt_flag;
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic [15:0] per_ff;
   logic [15:0] cmp_ff [3];
   logic dir_ff;
   logic [PRESC_W-1:0] presc_ff;
   logic evt_prev_ff;
   logic [7:0] rdata_ff;
   logic [4:0] evt_ff;
   logic [7:0] irq_ff;
   logic run_ff;
   logic split_out_ff;
   logic enable;
   logic presc_tick;
   logic use_evt;
   logic tick;
   logic down;
   logic [7:0] cond;
   logic wr_set;
   logic hard_rst;
   logic [2:0] act;

   assign enable = ctrl_a_ff[POS_ENABLE];
   assign act = evt_ctrl_ff[POS_EVT_ACT +: 3];
   assign wr_set = link.reg_we && link.reg_addr == ADDR_CONTROL_E_SET;
   // hard reset only takes effect while stopped
   assign hard_rst = wr_set && link.reg_wdata[POS_CMD +: 2] == TSE_CMD_RESET && !enable;

   // prescaler; no sleep input gates it, so it keeps going in idle sleep
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || !enable) begin
         presc_ff <= '0;
      end else begin
         presc_ff <= presc_ff + 10'h001;
      end
   end
   assign presc_tick = enable && ((presc_ff & div_mask(ctrl_a_ff[POS_PRESC +: 3]))
      == div_mask(ctrl_a_ff[POS_PRESC +: 3]));

   // event input history for edge detection; the link is on this clock
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         evt_prev_ff <= 1'b0;
      end else begin
         evt_prev_ff <= link.event_in;
      end
   end

   // count tick and direction selection
   always_comb begin
      use_evt = evt_ctrl_ff[POS_EVT_EN] && !split_ff;
      tick = presc_tick;
      down = dir_ff;
      if (use_evt) begin
         case (act)
            TSE_ACT_RISE: tick = enable && link.event_in && !evt_prev_ff;
            TSE_ACT_ANY_EDGE: tick = enable && (link.event_in ^ evt_prev_ff);
            TSE_ACT_HIGH: tick = presc_tick && link.event_in;
            TSE_ACT_UPDOWN: down = link.event_in;
            default: tick = presc_tick;
         endcase
      end
   end

   // next count and interrupt conditions for both modes
   always_comb begin
      nxt_cnt = cnt_ff;
      cond = 8'h00;
      if (tick && !split_ff) begin
         if (down) begin
            nxt_cnt = (cnt_ff == 16'h0000) ? per_ff : cnt_ff - 16'h0001;
            cond[FLAG_OVER_LOW] = cnt_ff == 16'h0000;
         end else begin
            nxt_cnt = (cnt_ff == per_ff) ? 16'h0000 : cnt_ff + 16'h0001;
            cond[FLAG_OVER_LOW] = cnt_ff == per_ff;
         end
         for (int n = 0; n < 3; n++) begin
            cond[FLAG_COMPARE + n] = cnt_ff == cmp_ff[n];
         end
      end else if (tick) begin
         // split: two independent down counters, period bytes reload them
         nxt_cnt[7:0] = (cnt_ff[7:0] == 8'h00) ? per_ff[7:0] : cnt_ff[7:0] - 8'h01;
         nxt_cnt[15:8] = (cnt_ff[15:8] == 8'h00) ? per_ff[15:8] : cnt_ff[15:8] - 8'h01;
         cond[FLAG_OVER_LOW] = cnt_ff[7:0] == 8'h00;
         cond[FLAG_HIGH_UNDER] = cnt_ff[15:8] == 8'h00;
         for (int n = 0; n < 3; n++) begin
            cond[FLAG_COMPARE + n] = cnt_ff[7:0] == cmp_ff[n][7:0];
         end
      end
   end

   // flags: a new condition wins over a clear in the same cycle
   always_comb begin
      nxt_flag = flag_ff;
      if (link.reg_we && link.reg_addr == ADDR_INT_FLAG) begin
         nxt_flag = flag_ff & ~link.reg_wdata;
      end
      nxt_flag = (nxt_flag | cond) & FLAG_MASK;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || hard_rst) begin
         flag_ff <= RST_BYTE;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // control registers; a mode switch rewrites only the split bit
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || hard_rst) begin
         ctrl_a_ff <= RST_CTRL;
         split_ff <= 1'b0;
         evt_ctrl_ff <= RST_CTRL;
         int_en_ff <= RST_BYTE;
      end else if (link.reg_we) begin
         case (link.reg_addr)
            ADDR_CONTROL_A: ctrl_a_ff <= link.reg_wdata[3:0];
            ADDR_CONTROL_D: split_ff <= link.reg_wdata[POS_SPLIT];
            ADDR_EVENT_CONTROL: evt_ctrl_ff <= link.reg_wdata[3:0];
            ADDR_INT_ENABLE: int_en_ff <= link.reg_wdata & FLAG_MASK;
            default: ;
         endcase
      end
   end

   // direction bit via set/clear pair; restart also clears it
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || hard_rst) begin
         dir_ff <= 1'b0;
      end else if (wr_set && link.reg_wdata[POS_CMD +: 2] == TSE_CMD_RESTART) begin
         dir_ff <= 1'b0;
      end else if (wr_set && link.reg_wdata[POS_DIR]) begin
         dir_ff <= 1'b1;
      end else if (link.reg_we && link.reg_addr == ADDR_CONTROL_E_CLR && link.reg_wdata[POS_DIR]) begin
         dir_ff <= 1'b0;
      end
   end

   // counter: software write and restart take priority over counting
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || hard_rst) begin
         cnt_ff <= RST_WORD;
      end else if (wr_set && link.reg_wdata[POS_CMD +: 2] == TSE_CMD_RESTART) begin
         cnt_ff <= RST_WORD;
      end else if (link.reg_we && link.reg_addr[5:1] == ADDR_COUNT_LO[5:1]) begin
         cnt_ff <= put_byte(cnt_ff, link.reg_addr[0], link.reg_wdata);
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // period and compare values, same bytes in both modes
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || hard_rst) begin
         per_ff <= RST_PERIOD;
         for (int n = 0; n < 3; n++) begin
            cmp_ff[n] <= RST_WORD;
         end
      end else if (link.reg_we) begin
         if (link.reg_addr[5:1] == ADDR_PERIOD_LO[5:1]) begin
            per_ff <= put_byte(per_ff, link.reg_addr[0], link.reg_wdata);
         end
         for (int n = 0; n < 3; n++) begin
            if (link.reg_addr[5:1] == ADDR_COMPARE_BASE[5:1] + 5'(n)) begin
               cmp_ff[n] <= put_byte(cmp_ff[n], link.reg_addr[0], link.reg_wdata);
            end
         end
      end
   end

   // event pulses come from the very conditions that set the flags
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         evt_ff <= 5'h00;
      end else begin
         evt_ff <= {cond[FLAG_COMPARE +: 3], cond[FLAG_HIGH_UNDER], cond[FLAG_OVER_LOW]};
      end
   end

   // requests follow flag and enable, one cycle behind
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         irq_ff <= RST_BYTE;
      end else begin
         irq_ff <= flag_ff & int_en_ff;
      end
   end

   // read data; unmapped offsets read zero
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || !link.reg_re) begin
         rdata_ff <= RST_BYTE;
      end else begin
         case (link.reg_addr)
            ADDR_CONTROL_A: rdata_ff <= {4'h0, ctrl_a_ff};
            ADDR_CONTROL_D: rdata_ff <= {7'h00, split_ff};
            ADDR_CONTROL_E_CLR, ADDR_CONTROL_E_SET: rdata_ff <= {7'h00, dir_ff};
            ADDR_EVENT_CONTROL: rdata_ff <= {4'h0, evt_ctrl_ff};
            ADDR_INT_ENABLE: rdata_ff <= int_en_ff;
            ADDR_INT_FLAG: rdata_ff <= flag_ff;
            ADDR_COUNT_LO: rdata_ff <= cnt_ff[7:0];
            ADDR_COUNT_HI: rdata_ff <= cnt_ff[15:8];
            ADDR_PERIOD_LO: rdata_ff <= per_ff[7:0];
            ADDR_PERIOD_HI: rdata_ff <= per_ff[15:8];
            6'h28: rdata_ff <= cmp_ff[0][7:0];
            6'h29: rdata_ff <= cmp_ff[0][15:8];
            6'h2A: rdata_ff <= cmp_ff[1][7:0];
            6'h2B: rdata_ff <= cmp_ff[1][15:8];
            6'h2C: rdata_ff <= cmp_ff[2][7:0];
            6'h2D: rdata_ff <= cmp_ff[2][15:8];
            default: rdata_ff <= RST_BYTE;
         endcase
      end
   end

   // status outputs
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         run_ff <= 1'b0;
         split_out_ff <= 1'b0;
      end else begin
         run_ff <= enable;
         split_out_ff <= split_ff;
      end
   end

   assign link.reg_rdata = rdata_ff;
   assign link.overflow_or_low_underflow_event = evt_ff[0];
   assign link.high_byte_underflow = evt_ff[1];
   assign link.compare_event = evt_ff[4:2];
   assign link.irq_request = irq_ff;
   assign o_running = run_ff;
   assign o_split_active = split_out_ff;
endmodule
`default_nettype wire

// ### design/tse_host.sv
// Purpose: event routing and interrupt collection end facing the timer
// Assumes: software port: address, write data, write/read strobes, read data next cycle
// Notes: timer accesses are posted; poll the busy bit before reading back
`timescale 1ns/100ps
`default_nettype none
module tse_host import tse_pkg::*; (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // software port
   input wire logic [1:0] i_sw_addr,
   input wire logic [15:0] i_sw_wdata,
   input wire logic i_sw_we,
   input wire logic i_sw_re,
   output logic [15:0] o_sw_rdata,
   // interrupt to the processor
   output logic o_irq,
   // link to the timer
   tse_if.host link
);
   logic [5:0] addr_ff;
   logic [7:0] wdata_ff;
   logic we_ff;
   logic re_ff;
   logic [1:0] pend_ff;
   logic [7:0] back_ff;
   logic evt_lvl_ff;
   logic [4:0] seen_ff;
   logic [4:0] evt_now;
   logic [15:0] rdata_ff;
   logic irq_ff;
   logic go;

   assign go = i_sw_we && i_sw_addr == HOST_ACCESS;
   assign evt_now = {link.compare_event, link.high_byte_underflow, link.overflow_or_low_underflow_event};

   // one-cycle access toward the timer: [7:0] data, [13:8] address, [14] write, [15] read
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         addr_ff <= 6'h00;
         wdata_ff <= RST_BYTE;
         we_ff <= 1'b0;
         re_ff <= 1'b0;
      end else begin
         addr_ff <= go ? i_sw_wdata[13:8] : addr_ff;
         wdata_ff <= go ? i_sw_wdata[7:0] : wdata_ff;
         we_ff <= go && i_sw_wdata[14];
         re_ff <= go && i_sw_wdata[15] && !i_sw_wdata[14];
      end
   end

   // read-back: timer data lands two cycles after the strobe
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         pend_ff <= 2'b00;
         back_ff <= RST_BYTE;
      end else begin
         pend_ff <= {pend_ff[0], re_ff};
         back_ff <= re_ff ? back_ff : (pend_ff[0] ? link.reg_rdata : back_ff);
      end
   end

   // routed event level; levels must change slower than the timer counts
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         evt_lvl_ff <= 1'b0;
      end else if (i_sw_we && i_sw_addr == HOST_EVENT) begin
         evt_lvl_ff <= i_sw_wdata[0];
      end
   end

   // sticky record of timer event pulses, set wins over clear
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         seen_ff <= 5'h00;
      end else if (i_sw_we && i_sw_addr == HOST_STATUS) begin
         seen_ff <= (seen_ff & ~i_sw_wdata[12:8]) | evt_now;
      end else begin
         seen_ff <= seen_ff | evt_now;
      end
   end

   // processor interrupt: any timer request line
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |link.irq_request;
      end
   end

   // software read data
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || !i_sw_re) begin
         rdata_ff <= 16'h0000;
      end else begin
         case (i_sw_addr)
            HOST_READBACK: rdata_ff <= {7'h00, re_ff | pend_ff[0] | pend_ff[1], back_ff};
            HOST_EVENT: rdata_ff <= {15'h0000, evt_lvl_ff};
            HOST_STATUS: rdata_ff <= {3'h0, seen_ff, link.irq_request};
            default: rdata_ff <= {2'h0, addr_ff, wdata_ff};
         endcase
      end
   end

   assign link.reg_addr = addr_ff;
   assign link.reg_wdata = wdata_ff;
   assign link.reg_we = we_ff;
   assign link.reg_re = re_ff;
   assign link.event_in = evt_lvl_ff;
   assign o_sw_rdata = rdata_ff;
   assign o_irq = irq_ff;
endmodule
`default_nettype wire

// ### dv/tse_link_sva.sv
// Purpose: concurrent checks on the link between timer and host
// Assumes: one clock, synchronous active-low reset
// Notes: enable, split and interrupt enables are shadowed from writes seen on the link
`timescale 1ns/100ps
`default_nettype none
module tse_link_sva import tse_pkg::*; (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [7:0] reg_rdata,
   // events and requests
   input wire logic event_in,
   input wire logic overflow_or_low_underflow_event,
   input wire logic high_byte_underflow,
   input wire logic [2:0] compare_event,
   input wire logic [7:0] irq_request
);
   logic en_ff;
   logic split_ff;
   logic [7:0] ien_ff;
   logic clr_d_ff;
   logic hard_w;
   logic clr_w;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   // a hard reset is refused while running, so the shadow must not follow it then
   assign hard_w = reg_we && reg_addr == ADDR_CONTROL_E_SET && reg_wdata[3:2] == 2'b11 && !en_ff;
   // writes that may legally drop a request
   assign clr_w = reg_we && (reg_addr == ADDR_INT_FLAG || reg_addr == ADDR_INT_ENABLE || hard_w);
   // shadow of enable, split and interrupt enables
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || hard_w) begin
         en_ff <= 1'b0;
         split_ff <= 1'b0;
         ien_ff <= 8'h00;
      end else if (reg_we) begin
         if (reg_addr == ADDR_CONTROL_A) en_ff <= reg_wdata[POS_ENABLE];
         if (reg_addr == ADDR_CONTROL_D) split_ff <= reg_wdata[POS_SPLIT];
         if (reg_addr == ADDR_INT_ENABLE) ien_ff <= reg_wdata;
      end
   end
   // request drop lags the clearing write by one cycle
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) clr_d_ff <= 1'b0;
      else clr_d_ff <= clr_w;
   end
   ovf_pulse_a: assert property (overflow_or_low_underflow_event |=> !overflow_or_low_underflow_event)
      else $error("overflow event held beyond one cycle");
   high_pulse_a: assert property (high_byte_underflow |=> !high_byte_underflow)
      else $error("high underflow event held beyond one cycle");
   cmp_pulse_a: assert property (|compare_event |=> (compare_event & $past(compare_event)) == 3'b000)
      else $error("compare event held beyond one cycle");
   high_split_only_a: assert property (high_byte_underflow |-> split_ff)
      else $error("high underflow event outside split mode");
   irq_needs_enable_a: assert property ((irq_request & ~(ien_ff | $past(ien_ff))) == 8'h00)
      else $error("request without its enable");
   ovf_to_irq_a: assert property (overflow_or_low_underflow_event && ien_ff[FLAG_OVER_LOW]
      |=> irq_request[FLAG_OVER_LOW])
      else $error("overflow event without request");
   cmp_to_irq_a: assert property (compare_event[0] && ien_ff[FLAG_COMPARE] |=> irq_request[FLAG_COMPARE])
      else $error("compare event without request");
   irq_holds_a: assert property (|irq_request && !clr_w && !clr_d_ff
      |=> (irq_request & $past(irq_request)) == $past(irq_request))
      else $error("request dropped without a clear");
   rdata_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   flag_bits_a: assert property ($past(reg_re && reg_addr == ADDR_INT_FLAG)
      |-> (reg_rdata & ~FLAG_MASK) == 8'h00)
      else $error("unused flag bit reads one");
endmodule
`default_nettype wire

// ### dv/tse_timer_tb.sv
// Purpose: self-checking bench for the split/event timer and its host end
// Assumes: host posts timer accesses and shows busy while a read is in flight
// Notes: runs of 20 cycles are far longer than the short periods used here
`timescale 1ns/100ps
`default_nettype none
module tse_timer_tb import tse_pkg::*; ();
   logic i_core_clk;
   logic i_reset_n;
   logic [1:0] sw_addr;
   logic [15:0] sw_wdata;
   logic sw_we;
   logic sw_re;
   logic [15:0] sw_rdata;
   logic irq;
   logic running;
   logic split_act;
   logic [15:0] v;
   int bad_count;
   int tests_run;
   logic [7:0] ien_tab [3] = '{8'h71, 8'h10, 8'h00};
   logic [7:0] cmp_tab [3] = '{8'h02, 8'h03, 8'h05};
   logic [7:0] evt_tab [3] = '{8'h00, 8'h01, 8'h03};
   logic [7:0] cnt_tab [3] = '{8'h00, 8'h02, 8'h04};
   logic [7:0] lvl_act [3] = '{8'h05, 8'h07, 8'h07};
   logic [7:0] lvl_exp [3] = '{8'h00, 8'h80, 8'h7F};
   logic [7:0] spl_cmp [3] = '{8'h02, 8'h01, 8'h10};
   tse_if link ();
   tse_timer i_tse_timer (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link),
      .o_running(running), .o_split_active(split_act));
   tse_host i_tse_host (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_sw_addr(sw_addr),
      .i_sw_wdata(sw_wdata), .i_sw_we(sw_we), .i_sw_re(sw_re), .o_sw_rdata(sw_rdata), .o_irq(irq), .link(link));
   tse_link_sva i_tse_link_sva (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .reg_addr(link.reg_addr),
      .reg_wdata(link.reg_wdata), .reg_we(link.reg_we), .reg_re(link.reg_re), .reg_rdata(link.reg_rdata),
      .event_in(link.event_in), .overflow_or_low_underflow_event(link.overflow_or_low_underflow_event),
      .high_byte_underflow(link.high_byte_underflow), .compare_event(link.compare_event),
      .irq_request(link.irq_request));
   // 125 MHz core clock
   initial begin
      i_core_clk = 1'b0;
      forever #4 i_core_clk = ~i_core_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one-cycle write strobe on the software port
   task automatic sw_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_we <= 1'b1;
      @(posedge i_core_clk);
      sw_we <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic sw_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge i_core_clk);
      sw_addr <= a;
      sw_re <= 1'b1;
      @(posedge i_core_clk);
      sw_re <= 1'b0;
      #1;
      d = sw_rdata;
   endtask
   // timer accesses are posted, so poll busy under a bound
   task automatic post(input logic [15:0] cmd, output logic [15:0] r);
      sw_wr(HOST_ACCESS, cmd);
      r = 16'h0100;
      for (int n = 0; n < 16 && r[8] !== 1'b0; n++) sw_rd(HOST_READBACK, r);
      if (r[8] !== 1'b0) check(r, 16'h0000);
   endtask
   task automatic tmr_wr(input logic [5:0] a, input logic [7:0] d);
      logic [15:0] r;
      post({2'b01, a, d}, r);
   endtask
   task automatic chk_tmr(input logic [5:0] a, input logic [7:0] e);
      logic [15:0] r;
      post({2'b10, a, 8'h00}, r);
      check({8'h00, r[7:0]}, {8'h00, e});
   endtask
   task automatic run20(input logic [7:0] ctrl);
      tmr_wr(ADDR_CONTROL_A, ctrl);
      repeat (20) @(posedge i_core_clk);
      tmr_wr(ADDR_CONTROL_A, 8'h00);
   endtask
   task automatic toggle2();
      repeat (2) begin
         sw_wr(HOST_EVENT, 16'h0001);
         sw_wr(HOST_EVENT, 16'h0000);
      end
   endtask
   // hang guard, far beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge i_core_clk);
      $display("watchdog expired");
      bad_count++;
      give_verdict();
   end
   initial begin
      i_reset_n = 1'b0;
      sw_addr = 2'h0;
      sw_wdata = 16'h0000;
      sw_we = 1'b0;
      sw_re = 1'b0;
      bad_count = 0;
      tests_run = 0;
      repeat (3) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      // normal mode: period 5, compares 2, 3, 5, three enable masks
      chk_tmr(6'h08, 8'h00);
      tmr_wr(ADDR_PERIOD_LO, 8'h05);
      tmr_wr(ADDR_PERIOD_HI, 8'h00);
      for (int k = 0; k < 3; k++) tmr_wr(ADDR_COMPARE_BASE + 6'(2 * k), cmp_tab[k]);
      for (int k = 0; k < 3; k++) begin
         tmr_wr(ADDR_INT_FLAG, 8'hFF);
         tmr_wr(ADDR_INT_ENABLE, ien_tab[k]);
         run20(8'h01);
         chk_tmr(ADDR_INT_FLAG, 8'h71);
         sw_rd(HOST_STATUS, v);
         check({8'h00, v[7:0]}, {8'h00, ien_tab[k] & 8'h71});
         check({15'h0000, irq}, {15'h0000, |ien_tab[k]});
      end
      check({11'h000, v[12:8]}, 16'h001D);
      tmr_wr(ADDR_INT_FLAG, 8'h00);
      chk_tmr(ADDR_INT_FLAG, 8'h71);
      tmr_wr(ADDR_INT_FLAG, 8'h11);
      chk_tmr(ADDR_INT_FLAG, 8'h60);
      // event input after a hard reset, slow prescaler so clock ticks never land
      tmr_wr(ADDR_CONTROL_E_SET, 8'h0C);
      chk_tmr(ADDR_PERIOD_HI, 8'hFF);
      tmr_wr(ADDR_CONTROL_A, 8'h0F);
      for (int k = 0; k < 3; k++) begin
         tmr_wr(ADDR_COUNT_LO, 8'h00);
         tmr_wr(ADDR_EVENT_CONTROL, evt_tab[k]);
         toggle2();
         chk_tmr(ADDR_COUNT_LO, cnt_tab[k]);
      end
      tmr_wr(ADDR_CONTROL_A, 8'h00);
      // level actions from 0x8000: high gate with low event, then direction low and high
      for (int k = 0; k < 3; k++) begin
         tmr_wr(ADDR_COUNT_LO, 8'h00);
         tmr_wr(ADDR_COUNT_HI, 8'h80);
         tmr_wr(ADDR_EVENT_CONTROL, lvl_act[k]);
         sw_wr(HOST_EVENT, {15'h0000, k == 2});
         run20(8'h01);
         chk_tmr(k == 0 ? ADDR_COUNT_LO : ADDR_COUNT_HI, lvl_exp[k]);
      end
      // split start-up: hard reset while stopped, split bit, period, enable
      tmr_wr(ADDR_CONTROL_E_SET, 8'h0C);
      tmr_wr(ADDR_CONTROL_D, 8'h01);
      tmr_wr(ADDR_PERIOD_LO, 8'h03);
      tmr_wr(ADDR_PERIOD_HI, 8'h05);
      for (int k = 0; k < 3; k++) tmr_wr(ADDR_COMPARE_BASE + 6'(2 * k), spl_cmp[k]);
      tmr_wr(ADDR_COMPARE_BASE + 6'h01, 8'h7E);
      tmr_wr(ADDR_EVENT_CONTROL, 8'h01);
      tmr_wr(ADDR_CONTROL_A, 8'h0F);
      check({15'h0000, running}, 16'h0001);
      toggle2();
      chk_tmr(ADDR_COUNT_LO, 8'h00);
      sw_wr(HOST_STATUS, 16'h1F00);
      run20(8'h01);
      check({15'h0000, split_act}, 16'h0001);
      check({15'h0000, running}, 16'h0000);
      chk_tmr(ADDR_INT_FLAG, 8'h33);
      sw_rd(HOST_STATUS, v);
      check({11'h000, v[12:8]}, 16'h000F);
      // leaving split keeps stored bytes
      tmr_wr(ADDR_CONTROL_D, 8'h00);
      chk_tmr(ADDR_PERIOD_LO, 8'h03);
      chk_tmr(ADDR_PERIOD_HI, 8'h05);
      chk_tmr(ADDR_COMPARE_BASE + 6'h01, 8'h7E);
      give_verdict();
   end
endmodule
`default_nettype wire
